// ### bcp_pkg.sv
`default_nettype none
package bcp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus geometry: printed offsets are register indices, byte address is index * 4
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int F_W = 8;
    localparam int G_W = 5;

    localparam logic [15:0] IDX_F_DIR = 16'hfebe;
    localparam logic [15:0] IDX_F_DATA = 16'hff6e;
    localparam logic [15:0] IDX_F_STATE = 16'hff5e;
    localparam logic [15:0] IDX_G_DIR = 16'hfefb;
    localparam logic [15:0] IDX_G_STATE = 16'hff5f;
    localparam logic [15:0] IDX_G_DATA = 16'hff6f;
    localparam logic [15:0] IDX_FUNC_CTRL = 16'hffac;
    localparam logic [15:0] IDX_SYS_CTRL = 16'hff39;

    localparam logic [ADDR_W-1:0] ADDR_F_DIR = {IDX_F_DIR, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_F_DATA = {IDX_F_DATA, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_F_STATE = {IDX_F_STATE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_G_DIR = {IDX_G_DIR, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_G_STATE = {IDX_G_STATE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_G_DATA = {IDX_G_DATA, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_FUNC_CTRL = {IDX_FUNC_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_SYS_CTRL = {IDX_SYS_CTRL, 2'h0};

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and writable masks
    localparam logic [REG_W-1:0] SYS_CTRL_RST = 8'h01;
    localparam logic [REG_W-1:0] SYS_CTRL_WMASK = 8'hbf;
    localparam logic [REG_W-1:0] FUNC_CTRL_RST = 8'h30;
    localparam logic [REG_W-1:0] FUNC_CTRL_WMASK = 8'hf8;
    localparam logic [F_W-1:0] F_DATA_RST = 8'h00;
    localparam logic [F_W-1:0] F_DIR_RST_EXT = 8'h80;
    localparam logic [F_W-1:0] F_DIR_RST_SINGLE = 8'h00;
    localparam logic [G_W-1:0] G_DATA_RST = 5'h00;
    localparam logic [G_W-1:0] G_DIR_RST_CS0 = 5'h10;
    localparam logic [G_W-1:0] G_DIR_RST_OTHER = 5'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int FC_WAIT_SEL = 7;
    localparam int FC_BUS_REQUEST_IN_PIN_SEL = 6;
    localparam int FC_CS_A_EN = 5;
    localparam int FC_CS_B_EN = 4;
    localparam int FC_AS_DIS = 3;
    localparam int SC_LWR_DIS = 2;

    // Pin positions
    localparam int PF_CLK = 7;
    localparam int PF_AS = 6;
    localparam int PF_RD = 5;
    localparam int PF_HWR = 4;
    localparam int PF_LWR = 3;
    localparam int PF_LOWER_COLUMN_STROBE = 2;
    localparam int PF_BACK = 1;
    localparam int PF_BUS_REQUEST_IN = 0;
    localparam int PG_CS0 = 4;
    localparam int PG_CS1 = 3;
    localparam int PG_CS2 = 2;
    localparam int PG_CS3 = 1;
    localparam int PG_CAS = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Operating modes and DRAM space codes
    localparam logic [2:0] MODE_4 = 3'h4;
    localparam logic [2:0] MODE_5 = 3'h5;
    localparam logic [2:0] MODE_6 = 3'h6;
    localparam logic [2:0] MODE_7 = 3'h7;
    localparam logic [2:0] DRAM_CAS_LO = 3'h1;
    localparam logic [2:0] DRAM_CAS_HI = 3'h3;

    typedef enum logic {BCP_LOAD, BCP_RUN} bcp_init_t;

endpackage : bcp_pkg
`default_nettype wire

// ### bcp_apb_slave.sv
`timescale 1ns/1ps
`default_nettype none
module bcp_apb_slave
    import bcp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    output logic pready,
    output logic [DATA_W-1:0] prdata,
    output logic pslverr,
    // Register file side
    input wire logic regHit,
    input wire logic [REG_W-1:0] regRdData,
    output logic regWrEn
);

    // One wait state: the answer is built in the first access cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else if (psel && penable && !pready)
        begin
            pready <= 1'b1;
            prdata <= (!pwrite && regHit) ? {{(DATA_W-REG_W){1'b0}}, regRdData} : '0;
            pslverr <= !regHit;
        end
        else
        begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end
    end

    assign regWrEn = psel && penable && pready && pwrite && regHit;

endmodule : bcp_apb_slave
`default_nettype wire

// ### bcp_pin_drive.sv
`timescale 1ns/1ps
`default_nettype none
module bcp_pin_drive
    import bcp_pkg::*;
#(
    parameter int W = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Standby controls
    input wire logic hwStandby,
    input wire logic swStandby,
    input wire logic standbyOutputKeep,
    // Wanted pin state
    input wire logic [W-1:0] nextOut,
    input wire logic [W-1:0] nextOeN,
    input wire logic [W-1:0] busMask,
    // Pins
    output logic [W-1:0] pinOut,
    output logic [W-1:0] pinOeN
);

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    pinOut[i] <= 1'b1;
                    pinOeN[i] <= 1'b1;
                end
                else if (hwStandby)
                begin
                    pinOut[i] <= 1'b1;
                    pinOeN[i] <= 1'b1;
                end
                else if (swStandby)
                begin
                    // Ports hold; bus strobes float unless asked to hold
                    if (busMask[i] && !standbyOutputKeep)
                    begin
                        pinOeN[i] <= 1'b1;
                    end
                end
                else
                begin
                    pinOut[i] <= nextOut[i];
                    pinOeN[i] <= nextOeN[i];
                end
            end
        end
    endgenerate

endmodule : bcp_pin_drive
`default_nettype wire

// ### bcp_pin_mux.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: F6 address strobe unless disabled; else GPIO
// R2: System control resets to 0x01, kept otherwise
// R3: F3 low write strobe unless disabled; else GPIO
// R4: F7 input, or clock output when direction set
// R5: F5/F4 read and high write strobes externally
// R6: F2 column strobe, then bus request, then GPIO
// R7: F1 bus acknowledge when bus release enabled
// R8: F0 bus request input when bus release enabled
// R9: G4 direction reset depends on mode; others clear
// R10: Port G direction write-only, upper bits ignored
// R11: Port G data bits 4-0, reset zero
// R12: Reserved port G data/state bits ignore writes
// R13: Pin state reads data where output, else pin
// R14: Pin state register is read-only
// R15: Function control resets 0x30, low bits read zero
// R16: Group A enable gates chip select 1
// R17: Group B enable gates chip selects 2, 3
// R18: G4 chip select 0 or input externally
// R19: G3 chip select 1 needs enable and direction
// R20: G2/G1 chip selects need enable and direction
// R21: G0 column strobe for DRAM codes 1 to 3
// R22: Software standby holds or floats bus outputs
// R23: Bus request routed to F2 or 5-3
// R24: Pin function follows registers next cycle
module bcp_pin_mux
    import bcp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic pready,
    output logic [DATA_W-1:0] prdata,
    output logic pslverr,
    // Operating state
    input wire logic [2:0] opMode,
    input wire logic hwStandby,
    input wire logic swStandby,
    input wire logic standbyOutputKeep,
    // Bus controller settings
    input wire logic [2:0] dramSpaceType,
    input wire logic areaBusWidth16,
    input wire logic busRequestOutEnable,
    input wire logic busReleaseEnable,
    // Bus controller strobes
    input wire logic sysClockLevel,
    input wire logic addressStrobe,
    input wire logic readStrobe,
    input wire logic highByteWriteStrobe,
    input wire logic lowByteWriteStrobe,
    input wire logic lowerColumnStrobe,
    input wire logic busRequestOut,
    input wire logic busAck,
    input wire logic chipSelectZero,
    input wire logic [3:1] chipSelect,
    input wire logic columnStrobe,
    output logic busRequestIn,
    // Port F pins
    input wire logic [F_W-1:0] portFIn,
    output logic [F_W-1:0] portFOut,
    output logic [F_W-1:0] portFOeN,
    // Port G pins
    input wire logic [G_W-1:0] portGIn,
    output logic [G_W-1:0] portGOut,
    output logic [G_W-1:0] portGOeN,
    // Alternate bus request pin 5-3
    output logic breqAltOut,
    output logic breqAltOeN
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    bcp_init_t initState;
    logic [F_W-1:0] fDirReg;
    logic [F_W-1:0] fDataReg;
    logic [G_W-1:0] gDirReg;
    logic [G_W-1:0] gDataReg;
    logic [REG_W-1:0] funcCtrlReg;
    logic [REG_W-1:0] sysCtrlReg;
    logic regHit;
    logic regWrEn;
    logic [REG_W-1:0] regRdData;
    logic [F_W-1:0] fOut;
    logic [F_W-1:0] fOeN;
    logic [F_W-1:0] fBus;
    logic [G_W-1:0] gOut;
    logic [G_W-1:0] gOeN;
    logic [G_W-1:0] gBus;
    logic extMode;
    logic lcasSel;
    logic casSel;
    logic breqOnF;
    logic breqOnAlt;
    logic pinsLive;
    logic [F_W-1:0] fState;
    logic [G_W-1:0] gState;

    assign extMode = (opMode == MODE_4) || (opMode == MODE_5) || (opMode == MODE_6);
    assign casSel = (dramSpaceType >= DRAM_CAS_LO) && (dramSpaceType <= DRAM_CAS_HI);
    assign lcasSel = casSel && areaBusWidth16;
    assign breqOnF = busRequestOutEnable && !funcCtrlReg[FC_BUS_REQUEST_IN_PIN_SEL];
    assign breqOnAlt = busRequestOutEnable && funcCtrlReg[FC_BUS_REQUEST_IN_PIN_SEL];
    assign pinsLive = !swStandby && !hwStandby;
    assign fState = (fDirReg & fDataReg) | (~fDirReg & portFIn); // R13
    assign gState = (gDirReg & gDataReg) | (~gDirReg & portGIn); // R13

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus
    bcp_apb_slave u_apb (
        .clk(clk),
        .nrst(nrst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .regHit(regHit),
        .regRdData(regRdData),
        .regWrEn(regWrEn)
    );

    // Address decode and read data
    always_comb
    begin
        regHit = 1'b1;
        regRdData = '0;
        if (paddr == ADDR_F_DIR)
        begin
            regRdData = '0;
        end
        else if (paddr == ADDR_F_DATA)
        begin
            regRdData = fDataReg;
        end
        else if (paddr == ADDR_F_STATE)
        begin
            regRdData = fState;
        end
        else if (paddr == ADDR_G_DIR)
        begin
            regRdData = '0; // R10
        end
        else if (paddr == ADDR_G_DATA)
        begin
            regRdData = {{(REG_W-G_W){1'b0}}, gDataReg}; // R12
        end
        else if (paddr == ADDR_G_STATE)
        begin
            regRdData = {{(REG_W-G_W){1'b0}}, gState}; // R13 R14
        end
        else if (paddr == ADDR_FUNC_CTRL)
        begin
            regRdData = funcCtrlReg; // R15
        end
        else if (paddr == ADDR_SYS_CTRL)
        begin
            regRdData = sysCtrlReg;
        end
        else
        begin
            regHit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode-dependent direction load after reset release and in hardware standby
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            initState <= BCP_LOAD;
        end
        else
        begin
            case (initState)
                BCP_LOAD: initState <= hwStandby ? BCP_LOAD : BCP_RUN;
                BCP_RUN: initState <= hwStandby ? BCP_LOAD : BCP_RUN;
                default: initState <= BCP_LOAD;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fDirReg <= F_DIR_RST_SINGLE;
            gDirReg <= G_DIR_RST_OTHER;
        end
        else if (hwStandby || initState == BCP_LOAD)
        begin
            fDirReg <= extMode ? F_DIR_RST_EXT : F_DIR_RST_SINGLE;
            gDirReg <= (opMode == MODE_4 || opMode == MODE_5) ? G_DIR_RST_CS0 : G_DIR_RST_OTHER; // R9
        end
        else if (regWrEn && paddr == ADDR_F_DIR)
        begin
            fDirReg <= pwdata[F_W-1:0];
        end
        else if (regWrEn && paddr == ADDR_G_DIR)
        begin
            gDirReg <= pwdata[G_W-1:0]; // R10
        end
    end

    // Data and control registers; software standby leaves them alone
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fDataReg <= F_DATA_RST;
            gDataReg <= G_DATA_RST;
        end
        else if (hwStandby)
        begin
            fDataReg <= F_DATA_RST;
            gDataReg <= G_DATA_RST; // R11
        end
        else if (regWrEn && paddr == ADDR_F_DATA)
        begin
            fDataReg <= pwdata[F_W-1:0];
        end
        else if (regWrEn && paddr == ADDR_G_DATA)
        begin
            gDataReg <= pwdata[G_W-1:0]; // R11 R12
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            funcCtrlReg <= FUNC_CTRL_RST;
            sysCtrlReg <= SYS_CTRL_RST;
        end
        else if (hwStandby)
        begin
            funcCtrlReg <= FUNC_CTRL_RST; // R15
            sysCtrlReg <= SYS_CTRL_RST; // R2
        end
        else if (regWrEn && paddr == ADDR_FUNC_CTRL)
        begin
            funcCtrlReg <= pwdata[REG_W-1:0] & FUNC_CTRL_WMASK; // R15
        end
        else if (regWrEn && paddr == ADDR_SYS_CTRL)
        begin
            sysCtrlReg <= pwdata[REG_W-1:0] & SYS_CTRL_WMASK; // R2
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin function selection, registered one cycle later
    always_comb
    begin
        fOut = fDataReg;
        fOeN = ~fDirReg;
        fBus = '0;
        gOut = gDataReg;
        gOeN = ~gDirReg;
        gBus = '0;
        // Clock output in every mode
        fOut[PF_CLK] = sysClockLevel; // R4
        fBus[PF_CLK] = fDirReg[PF_CLK];
        if (extMode)
        begin
            if (!funcCtrlReg[FC_AS_DIS])
            begin
                fOut[PF_AS] = addressStrobe; // R1
                fOeN[PF_AS] = 1'b0;
                fBus[PF_AS] = 1'b1;
            end
            fOut[PF_RD] = readStrobe; // R5
            fOeN[PF_RD] = 1'b0;
            fOut[PF_HWR] = highByteWriteStrobe;
            fOeN[PF_HWR] = 1'b0;
            fBus[PF_RD] = 1'b1;
            fBus[PF_HWR] = 1'b1;
            if (!sysCtrlReg[SC_LWR_DIS])
            begin
                fOut[PF_LWR] = lowByteWriteStrobe; // R3
                fOeN[PF_LWR] = 1'b0;
                fBus[PF_LWR] = 1'b1;
            end
            if (lcasSel)
            begin
                fOut[PF_LOWER_COLUMN_STROBE] = lowerColumnStrobe; // R6
                fOeN[PF_LOWER_COLUMN_STROBE] = 1'b0;
                fBus[PF_LOWER_COLUMN_STROBE] = 1'b1;
            end
            else if (breqOnF)
            begin
                fOut[PF_LOWER_COLUMN_STROBE] = busRequestOut; // R6 R23
                fOeN[PF_LOWER_COLUMN_STROBE] = 1'b0;
                fBus[PF_LOWER_COLUMN_STROBE] = 1'b1;
            end
            if (busReleaseEnable)
            begin
                fOut[PF_BACK] = busAck; // R7
                fOeN[PF_BACK] = 1'b0;
                fBus[PF_BACK] = 1'b1;
                fOeN[PF_BUS_REQUEST_IN] = 1'b1; // R8
            end
            // Chip select 0 or plain input, never a port output
            gOut[PG_CS0] = chipSelectZero; // R18
            gBus[PG_CS0] = gDirReg[PG_CS0];
            if (funcCtrlReg[FC_CS_A_EN] && gDirReg[PG_CS1])
            begin
                gOut[PG_CS1] = chipSelect[1]; // R16 R19
                gBus[PG_CS1] = 1'b1;
            end
            if (funcCtrlReg[FC_CS_B_EN] && gDirReg[PG_CS2])
            begin
                gOut[PG_CS2] = chipSelect[2]; // R17 R20
                gBus[PG_CS2] = 1'b1;
            end
            if (funcCtrlReg[FC_CS_B_EN] && gDirReg[PG_CS3])
            begin
                gOut[PG_CS3] = chipSelect[3]; // R17 R20
                gBus[PG_CS3] = 1'b1;
            end
            if (casSel)
            begin
                gOut[PG_CAS] = columnStrobe; // R21
                gOeN[PG_CAS] = 1'b0;
                gBus[PG_CAS] = 1'b1;
            end
        end
    end

    bcp_pin_drive #(.W(F_W)) u_drive_f (
        .clk(clk),
        .nrst(nrst),
        .hwStandby(hwStandby),
        .swStandby(swStandby),
        .standbyOutputKeep(standbyOutputKeep),
        .nextOut(fOut),
        .nextOeN(fOeN),
        .busMask(fBus),
        .pinOut(portFOut),
        .pinOeN(portFOeN)
    ); // R22 R24

    bcp_pin_drive #(.W(G_W)) u_drive_g (
        .clk(clk),
        .nrst(nrst),
        .hwStandby(hwStandby),
        .swStandby(swStandby),
        .standbyOutputKeep(standbyOutputKeep),
        .nextOut(gOut),
        .nextOeN(gOeN),
        .busMask(gBus),
        .pinOut(portGOut),
        .pinOeN(portGOeN)
    ); // R22 R24

    // Bus request input and its alternate output pin
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busRequestIn <= 1'b1;
            breqAltOut <= 1'b1;
            breqAltOeN <= 1'b1;
        end
        else
        begin
            busRequestIn <= (extMode && busReleaseEnable) ? portFIn[PF_BUS_REQUEST_IN] : 1'b1; // R8
            if (hwStandby)
            begin
                breqAltOut <= 1'b1;
                breqAltOeN <= 1'b1;
            end
            else if (swStandby)
            begin
                breqAltOeN <= breqAltOeN | !standbyOutputKeep; // R22
            end
            else
            begin
                breqAltOut <= busRequestOut; // R23
                breqAltOeN <= !(extMode && breqOnAlt);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence sRunExt;
        pinsLive && extMode && initState == BCP_RUN;
    endsequence

    sequence sGStateRead;
        psel && penable && !pwrite && paddr == ADDR_G_STATE && !pready ##1 pready;
    endsequence

    a_as_drive: assert property (sRunExt and !funcCtrlReg[FC_AS_DIS] |=> // R1
        !portFOeN[PF_AS] && portFOut[PF_AS] == $past(addressStrobe))
        else $error("address strobe not driven on F6");
    a_lwr_gpio: assert property (sRunExt and sysCtrlReg[SC_LWR_DIS] |=> // R3
        portFOeN[PF_LWR] == !$past(fDirReg[PF_LWR]))
        else $error("F3 not under its direction bit");
    a_clock_out: assert property (pinsLive && fDirReg[PF_CLK] |=> // R4
        !portFOeN[PF_CLK] && portFOut[PF_CLK] == $past(sysClockLevel))
        else $error("clock not driven on F7");
    a_read_strobe: assert property (sRunExt |=> // R5
        !portFOeN[PF_RD] && portFOut[PF_HWR] == $past(highByteWriteStrobe))
        else $error("read or high write strobe missing");
    a_lower_column_strobe_first: assert property (sRunExt and lcasSel |=> // R6
        portFOut[PF_LOWER_COLUMN_STROBE] == $past(lowerColumnStrobe))
        else $error("column strobe lost priority on F2");
    a_back_drive: assert property (sRunExt and busReleaseEnable |=> // R7
        !portFOeN[PF_BACK] && portFOut[PF_BACK] == $past(busAck))
        else $error("bus acknowledge not on F1");
    a_bus_request_in_input: assert property (extMode && busReleaseEnable |=> // R8
        busRequestIn == $past(portFIn[PF_BUS_REQUEST_IN]))
        else $error("bus request input not passed");
    a_cs0_init: assert property (initState == BCP_LOAD && !hwStandby && opMode == MODE_6 |=> // R9
        !gDirReg[PG_CS0] ##1 initState == BCP_RUN)
        else $error("G4 direction reset wrong");
    a_gstate_read: assert property (sGStateRead |-> // R13
        prdata[G_W-1:0] == $past(gState))
        else $error("port G state readback wrong");
    a_fc_reset: assert property (hwStandby |=> // R15
        funcCtrlReg == FUNC_CTRL_RST && sysCtrlReg == SYS_CTRL_RST)
        else $error("control registers not reset");
    a_cs1_gate: assert property (sRunExt and !funcCtrlReg[FC_CS_A_EN] |=> // R19
        portGOut[PG_CS1] == $past(gDataReg[PG_CS1]))
        else $error("chip select 1 leaked while disabled");
    a_bus_float: assert property (extMode && swStandby && !hwStandby && !standbyOutputKeep |=> // R22
        portFOeN[PF_RD] && portFOeN[PF_HWR])
        else $error("bus strobes not floated in standby");
    a_bus_request_in_route: assert property (sRunExt and breqOnAlt and !lcasSel |=> // R23
        !breqAltOeN && portFOeN[PF_LOWER_COLUMN_STROBE] == !$past(fDirReg[PF_LOWER_COLUMN_STROBE]))
        else $error("bus request routed to wrong pin");

endmodule : bcp_pin_mux
`default_nettype wire

// ### bcp_bus_dev.sv
`timescale 1ns/1ps
`default_nettype none
module bcp_bus_dev #(
    parameter int W = 8
)
(
    // Pins from the block
    input wire logic [W-1:0] pinOut,
    input wire logic [W-1:0] pinOeN,
    // Level the far devices put on released pins
    input wire logic [W-1:0] extDrive,
    output logic [W-1:0] pinLevel
);
    assign pinLevel = (pinOeN & extDrive) | (~pinOeN & pinOut);
endmodule : bcp_bus_dev
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import bcp_pkg::*;
;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, err, hwSb, brIn, swSb, keep, altO, altOeN;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [2:0] opMode, dram;
    logic [15:0] stb;
    logic [7:0] fIn, fOut, fOeN, fExt, fD, fc, sc;
    logic [4:0] gIn, gOut, gOeN, gExt, gD, gDat;
    int fails, compares, seed;

    bcp_pin_mux bcp_pin_mux_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .opMode(opMode), .hwStandby(hwSb), .swStandby(swSb),
        .standbyOutputKeep(keep), .dramSpaceType(dram), .areaBusWidth16(stb[13]),
        .busRequestOutEnable(stb[14]), .busReleaseEnable(stb[15]), .sysClockLevel(stb[0]),
        .addressStrobe(stb[1]), .readStrobe(stb[2]), .highByteWriteStrobe(stb[3]),
        .lowByteWriteStrobe(stb[4]), .lowerColumnStrobe(stb[5]), .busRequestOut(stb[6]),
        .busAck(stb[7]), .chipSelectZero(stb[8]), .chipSelect(stb[11:9]),
        .columnStrobe(stb[12]), .busRequestIn(brIn), .portFIn(fIn), .portFOut(fOut),
        .portFOeN(fOeN), .portGIn(gIn), .portGOut(gOut), .portGOeN(gOeN),
        .breqAltOut(altO), .breqAltOeN(altOeN));
    bcp_bus_dev #(.W(F_W)) devF (.pinOut(fOut), .pinOeN(fOeN), .extDrive(fExt), .pinLevel(fIn));
    bcp_bus_dev #(.W(G_W)) devG (.pinOut(gOut), .pinOeN(gOeN), .extDrive(gExt), .pinLevel(gIn));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            fails++;
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pinChk;
        logic ext, bus_release_enable, cas, alt;
        logic [4:0] bus, eo, eOeN, cs;
        logic [7:0] fo;
        ext = opMode != MODE_7;
        bus_release_enable = stb[15];
        cas = dram >= DRAM_CAS_LO && dram <= DRAM_CAS_HI;
        alt = ext & stb[14] & fc[6];
        cs = {stb[8], stb[9], stb[10], stb[11], stb[12]};
        bus = {ext & gD[4], ext & fc[5] & gD[3], ext & fc[4] & gD[2], ext & fc[4] & gD[1],
            ext & cas};
        eOeN = ~bus & ~gD;
        eo = (bus & cs) | (~bus & gDat);
        fo = ~fD;
        fo[6] = (ext & ~fc[3]) ? 1'b0 : ~fD[6];
        fo[5:4] = ext ? 2'h0 : ~fD[5:4];
        fo[3] = (ext & ~sc[2]) ? 1'b0 : ~fD[3];
        fo[2] = (ext & ((stb[13] & cas) | (stb[14] & ~fc[6]))) ? 1'b0 : ~fD[2];
        fo[1] = (ext & bus_release_enable) ? 1'b0 : ~fD[1];
        fo[0] = (ext & bus_release_enable) ? 1'b1 : ~fD[0];
        repeat (3) @(posedge clk);
        chk({gOeN, gOut & ~gOeN}, {eOeN, eo & ~eOeN});
        chk({fOeN, fOut[7] | fOeN[7]}, {fo, stb[0] | fo[7]});
        chk(brIn, (ext & bus_release_enable) ? fExt[0] : 1'b1);
        chk({altOeN, altO | altOeN}, {!alt, stb[6] | !alt});
        apb(1'b0, IDX_G_STATE, 8'h0);
        chk(rd, (gD & gDat) | (~gD & ((eOeN & gExt) | (~eOeN & eo))));
    endtask : pinChk

    task automatic chkRst;
        apb(1'b0, IDX_FUNC_CTRL, 8'h0);
        chk(rd, 32'h30);
        apb(1'b0, IDX_SYS_CTRL, 8'h0);
        chk(rd, 32'h01);
        apb(1'b0, IDX_G_DATA, 8'h0);
        chk(rd, 32'h0);
        fc = 8'h30;
        sc = 8'h01;
        gDat = 5'h0;
        gD = (opMode == MODE_4 || opMode == MODE_5) ? 5'h10 : 5'h0;
        fD = (opMode != MODE_7) ? 8'h80 : 8'h0;
        pinChk();
    endtask : chkRst

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end

    initial
    begin
        seed = 32'h7704ab6a;
        {nrst, psel, penable, pwrite, hwSb, swSb, keep, paddr, pwdata} = '0;
        {fails, compares, stb, fExt, gExt, dram} = '0;
        opMode = MODE_4;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        chkRst();
        apb(1'b0, 16'h0100, 8'h0);
        chk(err, 1'b1);
        apb(1'b0, IDX_G_DIR, 8'h0);
        chk(rd, 32'h0);
        repeat (24)
        begin
            opMode <= MODE_4 + 3'($random(seed) & 3);
            dram <= 3'($random(seed));
            stb <= 16'($random(seed));
            fExt <= 8'($random(seed));
            gExt <= 5'($random(seed));
            apb(1'b1, IDX_G_DIR, 8'h0);
            fc = 8'($random(seed));
            apb(1'b1, IDX_FUNC_CTRL, fc);
            fc = fc & FUNC_CTRL_WMASK;
            sc = 8'($random(seed));
            apb(1'b1, IDX_SYS_CTRL, sc);
            sc = sc & SYS_CTRL_WMASK;
            rd = 32'($random(seed));
            gD = rd[4:0];
            gDat = rd[12:8];
            fD = rd[23:16];
            apb(1'b1, IDX_G_DIR, {rd[7:5], gD});
            apb(1'b1, IDX_G_DATA, {fD[7:5], gDat});
            apb(1'b1, IDX_F_DIR, fD);
            apb(1'b1, IDX_G_STATE, 8'hff);
            apb(1'b0, IDX_G_DATA, 8'h0);
            chk(rd, {27'h0, gDat});
            apb(1'b0, IDX_FUNC_CTRL, 8'h0);
            chk(rd, {24'h0, fc});
            apb(1'b0, IDX_SYS_CTRL, 8'h0);
            chk(rd, {24'h0, sc});
            pinChk();
        end
        keep <= stb[1];
        swSb <= 1'b1;
        apb(1'b0, IDX_SYS_CTRL, 8'h0);
        chk(rd, {24'h0, sc});
        chk(fOeN[5:4], {(opMode == MODE_7) ? ~fD[5:4] : {2{!keep}}});
        swSb <= 1'b0;
        hwSb <= 1'b1;
        repeat (2) @(posedge clk);
        hwSb <= 1'b0;
        chkRst();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
